/* File: hdl/art_pkg.sv */
// Overview of operation
// (RULE1) High-byte rollover 0xFF to 0x00 sets high flag
// (RULE2) 16-bit wrap 0xFFFF to 0x0000 sets high flag
// (RULE3) Enabled timer interrupt plus high flag requests interrupt
// (RULE4) Overflow flags clear only by software
// (RULE5) Low-byte rollover sets low flag in any mode
// (RULE6) Low irq enable adds low-flag interrupt requests
// (RULE7) Control bits 4 and 1 read zero
// (RULE8) Split bit picks one 16-bit or two 8-bit
// (RULE9) Run gates whole timer, or high byte split
// (RULE10) External select: core/12 or synced external/8
// (RULE11) Per-byte selects may force undivided core clock
// (RULE12) Two writable 8-bit reload byte registers
// (RULE13) 16-bit wrap loads combined reload value
// (RULE14) Split bytes reload from their own bytes
// (RULE15) Per-byte select 1 means core clock
// (RULE16) Split: high overflow, or either with low enable
// (RULE17) Count one per tick; reload and flag same tick
package art_pkg;
    // Register offsets on the special-function bus
    localparam logic [7:0] ART_ADDR_CTRL = 8'hC8;
    localparam logic [7:0] ART_ADDR_RELOAD_LO = 8'hCA;
    localparam logic [7:0] ART_ADDR_COUNT_LO = 8'hCC;
    localparam logic [7:0] ART_ADDR_COUNT_HI = 8'hCD;
    localparam logic [7:0] ART_ADDR_RELOAD_HI = 8'hCE;
    // Control register field positions
    localparam int ART_BIT_HIGH_FLAG = 7;
    localparam int ART_BIT_LOW_FLAG = 6;
    localparam int ART_BIT_LOW_IRQ_EN = 5;
    localparam int ART_BIT_SPLIT = 3;
    localparam int ART_BIT_RUN = 2;
    localparam int ART_BIT_EXT_SEL = 0;
    // Writable bits of the control register; bits 4 and 1 are not kept
    localparam logic [7:0] ART_CTRL_MASK = 8'hED;
    // Reset values
    localparam logic [7:0] ART_CTRL_RESET = 8'h00;
    localparam logic [7:0] ART_RELOAD_RESET = 8'h00;
    localparam logic [7:0] ART_COUNT_RESET = 8'h00;
    // Prescaler ratios and byte maximum
    localparam int ART_CORE_DIV = 12;
    localparam int ART_EXT_DIV = 8;
    localparam logic [7:0] ART_BYTE_MAX = 8'hFF;
endpackage

/* File: hdl/art_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Prescaled tick strobes passed from the prescaler to the timer core
interface art_tick_if;
    logic core_div_tick; // One-cycle pulse every twelfth core clock
    logic ext_div_tick; // One-cycle pulse every eighth external edge
    modport src (output core_div_tick, output ext_div_tick);
    modport snk (input core_div_tick, input ext_div_tick);
endinterface
`default_nettype wire

/* File: hdl/art_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
// Core-clock /12 and external-clock /8 tick generator
module art_prescaler
    import art_pkg::*;
#(
    parameter int CORE_DIV = ART_CORE_DIV,
    parameter int EXT_DIV = ART_EXT_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_osc_clk,
    art_tick_if.src ticks
);
    localparam int CW = $clog2(CORE_DIV);
    localparam int EW = $clog2(EXT_DIV);
    localparam logic [CW-1:0] CORE_LAST = CW'(CORE_DIV - 1);
    localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

    logic [CW-1:0] core_cnt_q, core_cnt_d; // Core divider count
    logic [EW-1:0] ext_cnt_q, ext_cnt_d; // External edge count
    logic ext_prev_q, ext_prev_d; // Last sampled external level
    logic ext_rise; // External rising edge seen this cycle

    // Next-state for both dividers
    always_comb begin
        ext_rise = ext_osc_clk & ~ext_prev_q;
        ext_prev_d = ext_osc_clk;
        core_cnt_d = (core_cnt_q == CORE_LAST) ? '0 : core_cnt_q + 1'b1; // [RULE10]
        ext_cnt_d = ext_cnt_q;
        if (ext_rise) begin
            ext_cnt_d = (ext_cnt_q == EXT_LAST) ? '0 : ext_cnt_q + 1'b1; // [RULE10]
        end
    end

    // Divider registers
    always_ff @(posedge clk) begin
        if (rst) begin
            core_cnt_q <= '0;
            ext_cnt_q <= '0;
            ext_prev_q <= 1'b0;
        end else begin
            core_cnt_q <= core_cnt_d;
            ext_cnt_q <= ext_cnt_d;
            ext_prev_q <= ext_prev_d;
        end
    end

    // Ticks are one-cycle strobes aligned to the core clock
    assign ticks.core_div_tick = (core_cnt_q == CORE_LAST);
    assign ticks.ext_div_tick = ext_rise & (ext_cnt_q == EXT_LAST);
endmodule
`default_nettype wire

/* File: hdl/art_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Auto-reload timer: control register, reload bytes, counter and flags
module art_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic ext_osc_clk,
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    input wire logic timer_irq_enable,
    output logic irq_request,
    output logic [15:0] count_value
);
    import art_pkg::*;

    art_tick_if ticks (); // Prescaled strobes

    // Prescaler for the two divided sources
    art_prescaler #(
        .CORE_DIV(ART_CORE_DIV),
        .EXT_DIV(ART_EXT_DIV)
    ) u_prescaler (
        .clk(clk),
        .rst(rst),
        .ext_osc_clk(ext_osc_clk),
        .ticks(ticks)
    );

    logic [7:0] ctrl_q, ctrl_d; // Control and status
    logic [7:0] reload_lo_q, reload_lo_d; // Reload low byte
    logic [7:0] reload_hi_q, reload_hi_d; // Reload high byte
    logic [7:0] cnt_lo_q, cnt_lo_d; // Counter low byte
    logic [7:0] cnt_hi_q, cnt_hi_d; // Counter high byte
    logic [7:0] rdata_q, rdata_d; // Read data register
    logic prescaled_tick; // Tick from /12 or external /8
    logic lo_tick, hi_tick; // Per-byte enabled ticks
    logic lo_wrap, hi_wrap; // Rollover events this cycle
    logic split, run, ext_sel;
    logic wr_ctrl;

    // Tick selection and wrap detection
    always_comb begin
        split = ctrl_q[ART_BIT_SPLIT];
        run = ctrl_q[ART_BIT_RUN];
        ext_sel = ctrl_q[ART_BIT_EXT_SEL];
        // Prescaled source choice
        prescaled_tick = ext_sel ? ticks.ext_div_tick : ticks.core_div_tick; // [RULE10]
        if (split) begin // [RULE8]
            // Low byte always counts; run gates only the high byte
            lo_tick = low_byte_clock_select ? 1'b1 : prescaled_tick; // [RULE11] [RULE15] [RULE9]
            hi_tick = run // [RULE9]
                & (high_byte_clock_select ? 1'b1 : prescaled_tick); // [RULE11] [RULE15]
            lo_wrap = lo_tick & (cnt_lo_q == ART_BYTE_MAX); // [RULE5]
            hi_wrap = hi_tick & (cnt_hi_q == ART_BYTE_MAX); // [RULE1]
        end else begin
            // Whole 16-bit counter gated by run, clocked by the low-byte select
            lo_tick = run // [RULE9]
                & (low_byte_clock_select ? 1'b1 : prescaled_tick); // [RULE11] [RULE15]
            hi_tick = lo_tick;
            lo_wrap = lo_tick & (cnt_lo_q == ART_BYTE_MAX); // [RULE5]
            hi_wrap = lo_wrap & (cnt_hi_q == ART_BYTE_MAX); // [RULE2]
        end
    end

    // Counter next value
    always_comb begin
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        if (split) begin
            // Each byte reloads from its own reload byte
            if (lo_wrap) begin
                cnt_lo_d = reload_lo_q; // [RULE14] [RULE17]
            end else if (lo_tick) begin
                cnt_lo_d = cnt_lo_q + 8'h01; // [RULE17]
            end
            if (hi_wrap) begin
                cnt_hi_d = reload_hi_q; // [RULE14] [RULE17]
            end else if (hi_tick) begin
                cnt_hi_d = cnt_hi_q + 8'h01; // [RULE17]
            end
        end else begin
            if (hi_wrap) begin
                // Full wrap loads the combined reload value
                cnt_lo_d = reload_lo_q; // [RULE13] [RULE17]
                cnt_hi_d = reload_hi_q; // [RULE13]
            end else if (lo_tick) begin
                cnt_lo_d = cnt_lo_q + 8'h01; // [RULE17]
                cnt_hi_d = lo_wrap ? cnt_hi_q + 8'h01 : cnt_hi_q;
            end
        end
        // Software write to a count byte overrides counting
        if (sfr_wr && sfr_addr == ART_ADDR_COUNT_LO) begin
            cnt_lo_d = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == ART_ADDR_COUNT_HI) begin
            cnt_hi_d = sfr_wdata;
        end
    end

    // Control, reload and read-data next values
    always_comb begin
        wr_ctrl = sfr_wr && (sfr_addr == ART_ADDR_CTRL);
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            // Unused bits are dropped on write
            ctrl_d = sfr_wdata & ART_CTRL_MASK; // [RULE7] [RULE4]
        end
        // Hardware only ever sets the flags; a set beats a same-cycle clear
        if (hi_wrap) begin
            ctrl_d[ART_BIT_HIGH_FLAG] = 1'b1; // [RULE1] [RULE2] [RULE17]
        end
        if (lo_wrap) begin
            ctrl_d[ART_BIT_LOW_FLAG] = 1'b1; // [RULE5] [RULE17]
        end
        // Reload byte registers
        reload_lo_d = (sfr_wr && sfr_addr == ART_ADDR_RELOAD_LO) // [RULE12]
            ? sfr_wdata : reload_lo_q;
        reload_hi_d = (sfr_wr && sfr_addr == ART_ADDR_RELOAD_HI) // [RULE12]
            ? sfr_wdata : reload_hi_q;
        // Read mux; unmapped addresses read zero
        unique case (sfr_addr)
            ART_ADDR_CTRL: begin
                rdata_d = ctrl_q & ART_CTRL_MASK; // [RULE7]
            end
            ART_ADDR_RELOAD_LO: begin
                rdata_d = reload_lo_q;
            end
            ART_ADDR_RELOAD_HI: begin
                rdata_d = reload_hi_q;
            end
            ART_ADDR_COUNT_LO: begin
                rdata_d = cnt_lo_q;
            end
            ART_ADDR_COUNT_HI: begin
                rdata_d = cnt_hi_q;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= ART_CTRL_RESET;
            reload_lo_q <= ART_RELOAD_RESET;
            reload_hi_q <= ART_RELOAD_RESET;
            cnt_lo_q <= ART_COUNT_RESET;
            cnt_hi_q <= ART_COUNT_RESET;
            rdata_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            reload_lo_q <= reload_lo_d;
            reload_hi_q <= reload_hi_d;
            cnt_lo_q <= cnt_lo_d;
            cnt_hi_q <= cnt_hi_d;
            rdata_q <= rdata_d;
        end
    end

    // Interrupt request follows the sticky flags while enabled
    assign irq_request = timer_irq_enable & (ctrl_q[ART_BIT_HIGH_FLAG] // [RULE3] [RULE16]
        | (ctrl_q[ART_BIT_LOW_IRQ_EN] & ctrl_q[ART_BIT_LOW_FLAG])); // [RULE6] [RULE16]
    assign sfr_rdata = rdata_q;
    assign count_value = {cnt_hi_q, cnt_lo_q};
endmodule
`default_nettype wire

/* File: bench/art_timer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the auto-reload timer
module art_timer_chk
    import art_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic ext_osc_clk,
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    input wire logic timer_irq_enable,
    input wire logic irq_request,
    input wire logic [15:0] count_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] rl_lo_q; // Shadow of the low reload byte
    logic [7:0] rl_hi_q; // Shadow of the high reload byte
    logic [7:0] ctl_q; // Shadow of software mode bits
    logic cnt_wr; // Software write to a count byte
    assign cnt_wr = sfr_wr && (sfr_addr == ART_ADDR_COUNT_LO || sfr_addr == ART_ADDR_COUNT_HI);
    // Follow software writes so reload and mode are known here
    always_ff @(posedge clk) begin
        if (rst) begin
            rl_lo_q <= 8'h00;
            rl_hi_q <= 8'h00;
            ctl_q <= 8'h00;
        end else if (sfr_wr) begin
            rl_lo_q <= (sfr_addr == ART_ADDR_RELOAD_LO) ? sfr_wdata : rl_lo_q;
            rl_hi_q <= (sfr_addr == ART_ADDR_RELOAD_HI) ? sfr_wdata : rl_hi_q;
            ctl_q <= (sfr_addr == ART_ADDR_CTRL) ? sfr_wdata : ctl_q;
        end
    end
    a_reset_clears_all: assert property (disable iff (1'b0) rst |=>
        (sfr_rdata == 8'h00 && count_value == 16'h0000 && !irq_request))
        else $error("outputs not cleared by reset");
    a_unused_bits_zero: assert property (sfr_addr == ART_ADDR_CTRL |=>
        (sfr_rdata & ~ART_CTRL_MASK) == 8'h00) else $error("unused control bit read one");
    a_reload_read_back: assert property ((sfr_wr && sfr_addr == ART_ADDR_RELOAD_LO)
        ##1 (!sfr_wr && sfr_addr == ART_ADDR_RELOAD_LO) |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("reload byte not read back");
    a_irq_needs_enable: assert property (!timer_irq_enable |-> !irq_request)
        else $error("interrupt without timer enable");
    a_wide_wrap_reload: assert property ((!ctl_q[3] && count_value == 16'hFFFF
        && !cnt_wr)
        |=> (count_value == 16'hFFFF || count_value == $past({rl_hi_q, rl_lo_q})))
        else $error("16-bit wrap did not load reload value");
    a_wide_wrap_irq: assert property ((!ctl_q[3] && count_value == 16'hFFFF && !cnt_wr)
        |=> (count_value == 16'hFFFF || irq_request || !timer_irq_enable))
        else $error("16-bit wrap raised no request");
    a_split_low_reload: assert property ((ctl_q[3] && count_value[7:0] == 8'hFF
        && !cnt_wr)
        |=> (count_value[7:0] == 8'hFF || count_value[7:0] == $past(rl_lo_q)))
        else $error("split low byte reload wrong");
    a_run_gates_high: assert property ((!ctl_q[2] && !cnt_wr)
        |=> $stable(count_value[15:8])) else $error("high byte moved while stopped");
    a_count_steps_one: assert property ((!ctl_q[3] && count_value != 16'hFFFF
        && !cnt_wr)
        |=> (count_value == $past(count_value) || count_value == $past(count_value) + 16'h0001))
        else $error("count stepped by more than one");
    c_wide_wrap: cover property (!ctl_q[3] && count_value == 16'hFFFF ##1 count_value != 16'hFFFF);
    c_split_wrap: cover property (ctl_q[3] && count_value[7:0] == 8'hFF);
    c_irq_rise: cover property ($rose(irq_request));
endmodule
bind art_timer art_timer_chk art_timer_chk_inst (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_osc_clk(ext_osc_clk),
    .high_byte_clock_select(high_byte_clock_select), .low_byte_clock_select(low_byte_clock_select),
    .timer_irq_enable(timer_irq_enable), .irq_request(irq_request), .count_value(count_value));
`default_nettype wire

/* File: bench/art_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// Register-level bench for the auto-reload timer
module art_timer_bench;
    import art_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic ext_clk = 1'b0;
    logic hsel = 1'b0;
    logic lsel = 1'b0;
    logic irq_en = 1'b1;
    logic [7:0] sfr_rdata;
    logic irq;
    logic [15:0] cnt;
    int miscompares = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    art_timer art_timer_inst (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_osc_clk(ext_clk),
        .high_byte_clock_select(hsel), .low_byte_clock_select(lsel),
        .timer_irq_enable(irq_en), .irq_request(irq), .count_value(cnt));
    // Closing report and end of run
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Masked compare of a result
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
        compares++;
        if ((got & msk) !== (exp & msk)) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One register write, strobe held across one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        @(negedge clk);
    endtask
    // Register read; data lags the address by one edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        sfr_addr = a;
        @(negedge clk);
        @(negedge clk);
        chk({8'h00, sfr_rdata}, {8'h00, exp}, {8'h00, msk});
    endtask
    // Bounded wait for the count to reach a value
    task automatic wait_cnt(input logic [15:0] v, input logic [15:0] m);
        int n;
        n = 0;
        while ((cnt & m) !== (v & m) && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk(cnt, v, m);
        if (n == 2000) print_verdict();
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rd(ART_ADDR_CTRL, 8'h00, 8'hFF);
        rd(ART_ADDR_RELOAD_LO, 8'h00, 8'hFF);
        rd(ART_ADDR_RELOAD_HI, 8'h00, 8'hFF);
        wr(8'hC9, 8'hFF);
        rd(8'hC9, 8'h00, 8'hFF);
        wr(ART_ADDR_CTRL, 8'hFF);
        rd(ART_ADDR_CTRL, 8'hED, 8'hFF);
        chk({15'h0000, irq}, 16'h0001, 16'h0001);
        irq_en = 1'b0;
        repeat (30) @(negedge clk);
        chk({15'h0000, irq}, 16'h0000, 16'h0001);
        irq_en = 1'b1;
        rd(ART_ADDR_CTRL, 8'hED, 8'hFF);
        wr(ART_ADDR_CTRL, 8'h00);
        rd(ART_ADDR_CTRL, 8'h00, 8'hFF);
        $display("registers done");
        // Full 16-bit wrap with reload
        wr(ART_ADDR_COUNT_LO, 8'hFF);
        wr(ART_ADDR_COUNT_HI, 8'hFF);
        wr(ART_ADDR_RELOAD_LO, 8'h34);
        wr(ART_ADDR_RELOAD_HI, 8'h12);
        lsel = 1'b1;
        wr(ART_ADDR_CTRL, 8'h04);
        wait_cnt(16'h1234, 16'hFFFF);
        chk({15'h0000, irq}, 16'h0001, 16'h0001);
        rd(ART_ADDR_CTRL, 8'hC4, 8'hFF);
        // Low-byte wrap with and without its interrupt enable
        for (int e = 0; e < 2; e++) begin
            wr(ART_ADDR_CTRL, 8'h00);
            wr(ART_ADDR_COUNT_HI, 8'h00);
            wr(ART_ADDR_COUNT_LO, 8'hFF);
            wr(ART_ADDR_CTRL, (e == 1) ? 8'h24 : 8'h04);
            wait_cnt(16'h0100, 16'hFF00);
            chk({15'h0000, irq}, e[15:0], 16'h0001);
            rd(ART_ADDR_CTRL, (e == 1) ? 8'h64 : 8'h44, 8'hFF);
        end
        $display("wide mode done");
        // Split mode: low byte free-running, high byte gated by run
        wr(ART_ADDR_CTRL, 8'h08);
        wr(ART_ADDR_RELOAD_LO, 8'h80);
        wr(ART_ADDR_COUNT_HI, 8'h05);
        wr(ART_ADDR_COUNT_LO, 8'hFE);
        wait_cnt(16'h0580, 16'hFFFF);
        chk({15'h0000, irq}, 16'h0000, 16'h0001);
        rd(ART_ADDR_CTRL, 8'h48, 8'hFF);
        hsel = 1'b1;
        wr(ART_ADDR_RELOAD_HI, 8'h77);
        wr(ART_ADDR_COUNT_HI, 8'hFF);
        wr(ART_ADDR_CTRL, 8'h0C);
        wait_cnt(16'h7700, 16'hFF00);
        chk({15'h0000, irq}, 16'h0001, 16'h0001);
        rd(ART_ADDR_CTRL, 8'h80, 8'h80);
        $display("split mode done");
        // Prescaled sources: external /8, then core /12
        hsel = 1'b0;
        lsel = 1'b0;
        wr(ART_ADDR_CTRL, 8'h00);
        wr(ART_ADDR_COUNT_HI, 8'h00);
        wr(ART_ADDR_COUNT_LO, 8'h00);
        wr(ART_ADDR_CTRL, 8'h05);
        repeat (16) begin
            ext_clk = 1'b1;
            repeat (2) @(negedge clk);
            ext_clk = 1'b0;
            repeat (2) @(negedge clk);
        end
        repeat (8) @(negedge clk);
        chk(cnt, 16'h0002, 16'hFFFF);
        wr(ART_ADDR_CTRL, 8'h00);
        wr(ART_ADDR_COUNT_LO, 8'h00);
        wr(ART_ADDR_CTRL, 8'h04);
        // Core divider phase is free-running; align on the first tick, then ten more
        wait_cnt(16'h0001, 16'hFFFF);
        repeat (120) @(negedge clk);
        chk(cnt, 16'h000B, 16'hFFFF);
        $display("prescaler done");
        print_verdict();
    end
endmodule
`default_nettype wire
